// file: logic/bcrc_top.sv
// Bus acknowledge checking, retry abort, push reservation and reset configuration
// Behaviour
// - Machine check on missing ack only if enabled
// - Ack check enable clears on hard reset
// - Enable off turns absent ack into confirmed
// - Abort operation one cycle after sampled retry
// - Queue-full retries suppressed from one cycle after a sampled retry until the next issue
// - One store buffer reserved for snoop pushes
// - Reprioritize pending work after a retry of the in-flight tenure
// - Fair arbitration guarantees snoop push issues
// - Scan pins configure only with scan disabled
// - Capture clock gating and bus ratio pins
// - Capture charge pump and VCO divider pins
// - Capture response timing and data extension
// - Capture five-bit processor id from pins
// - Flag sets on missing ack; a write clears it unless a miss comes in the same cycle
// - Register reads zero except ack enable, error flag and captured ratio, gating, timing, extension and pump fields
`timescale 1ns/100ps
`default_nettype none

module bcrc_top
(
    // Clock and hard reset
    input  wire logic                 sys_clk,
    input  wire logic                 arst_n,
    // Configuration pins
    input  wire bcrc_pkg::bcrc_pins_t cfg_pins,
    input  wire logic                 scan_test_disable,
    // Control register write port
    input  wire logic                 csr_wr,
    input  wire logic                 csr_wr_ack_en,
    // Bus operation status from bus logic
    input  wire logic                 op_active,
    input  wire logic                 op_expects_ack,
    input  wire logic [1:0]           ack_reply,
    input  wire logic [1:0]           addr_status_input,
    input  wire logic                 queue_full,
    // Internal store requests
    input  wire bcrc_pkg::bcrc_req_t  req_in,
    input  wire logic                 req_valid,
    input  wire logic                 issue_done,
    // Outputs
    output var  logic                 req_ready,
    output var  logic                 bus_request,
    output var  bcrc_pkg::bcrc_req_t  issue_req,
    output var  logic                 op_abort,
    output var  logic                 op_ack_ok,
    output var  logic                 machine_check,
    output var  logic                 addr_status_output,
    output var  logic                 addr_response_output,
    output var  logic [63:0]          csr_read,
    output var  bcrc_pkg::bcrc_cfg_t  cfg_out
);

    bcrc_pkg::bcrc_cfg_t cfg;
    logic                cfg_done;
    logic                ack_error_check_enable_reg;
    logic                ack_missing_flag_reg;
    logic                retry_seen_reg;
    logic                aborted_reg;
    logic                missing_ack;
    logic                retry_now;
    bcrc_pkg::bcrc_req_t buf_reg [bcrc_pkg::NUM_BUF];
    logic [bcrc_pkg::NUM_BUF-1:0] buf_vld_reg;
    logic [1:0]          rr_ptr_reg;
    logic [1:0]          free_idx;
    logic                free_ok;
    logic [1:0]          pick_idx;
    logic                pick_ok;
    logic                inflight_reg;
    logic [1:0]          inflight_idx_reg;

    bcrc_cfg_capture u_cfg
    (
        .sys_clk           (sys_clk),
        .arst_n            (arst_n),
        .pins              (cfg_pins),
        .scan_test_disable (scan_test_disable),
        .cfg               (cfg),
        .cfg_done          (cfg_done)
    );

    assign missing_ack = op_active && op_expects_ack && ack_reply == bcrc_pkg::ACK_ABSENT;
    assign retry_now   = op_active && addr_status_input == bcrc_pkg::ASTAT_RETRY;

    // Ack enable and error flag; a miss in the clearing cycle still sets the flag
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ack_error_check_enable_reg <= 1'b0;
            ack_missing_flag_reg       <= 1'b0;
        end
        else
        begin
            if (csr_wr)
                ack_error_check_enable_reg <= csr_wr_ack_en;
            if (missing_ack)
                ack_missing_flag_reg <= 1'b1;
            else if (csr_wr)
                ack_missing_flag_reg <= 1'b0;
        end
    end

    // Ack outcome and machine check
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            op_ack_ok     <= 1'b0;
            machine_check <= 1'b0;
        end
        else
        begin
            op_ack_ok <= op_active && (ack_reply == bcrc_pkg::ACK_CONFIRMED
                || (ack_reply == bcrc_pkg::ACK_ABSENT && op_expects_ack
                    && !ack_error_check_enable_reg));
            machine_check <= missing_ack && ack_error_check_enable_reg;
        end
    end

    // Retry sampled, abort one cycle later; aborted op marked until next issue
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            retry_seen_reg <= 1'b0;
            op_abort       <= 1'b0;
            aborted_reg    <= 1'b0;
        end
        else
        begin
            retry_seen_reg <= retry_now;
            op_abort       <= retry_seen_reg;
            if (retry_seen_reg)
                aborted_reg <= 1'b1;
            else if (bus_request)
                aborted_reg <= 1'b0;
        end
    end

    // Queue-full retries out are suppressed while an aborted op lingers
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            addr_status_output   <= 1'b0;
            addr_response_output <= 1'b0;
        end
        else
        begin
            addr_status_output   <= queue_full && !aborted_reg && !retry_seen_reg;
            addr_response_output <= queue_full && !aborted_reg && !retry_seen_reg;
        end
    end

    // Free slot search; last slot only for snoop pushes
    always_comb
    begin
        free_ok  = 1'b0;
        free_idx = 2'h0;
        if (req_in.is_push && req_in.snoop && !buf_vld_reg[bcrc_pkg::PUSH_BUF])
        begin
            free_ok  = 1'b1;
            free_idx = bcrc_pkg::PUSH_BUF_IDX;
        end
        else
        begin
            for (int i = bcrc_pkg::PUSH_BUF - 1; i >= 0; i--)
            begin
                if (!buf_vld_reg[i])
                begin
                    free_ok  = 1'b1;
                    free_idx = 2'(i);
                end
            end
        end
    end

    // Round robin from the pointer; reserved slot is always visited in turn
    always_comb
    begin
        pick_ok  = 1'b0;
        pick_idx = 2'h0;
        for (int k = bcrc_pkg::NUM_BUF - 1; k >= 0; k--)
        begin
            if (buf_vld_reg[2'(rr_ptr_reg + 2'(k))])
            begin
                pick_ok  = 1'b1;
                pick_idx = 2'(rr_ptr_reg + 2'(k));
            end
        end
    end

    // Buffer storage
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            buf_vld_reg <= '0;
            for (int i = 0; i < bcrc_pkg::NUM_BUF; i++)
                buf_reg[i] <= '0;
        end
        else
        begin
            if (inflight_reg && issue_done)
                buf_vld_reg[inflight_idx_reg] <= 1'b0;
            if (req_valid && req_ready)
            begin
                buf_vld_reg[free_idx] <= 1'b1;
                buf_reg[free_idx]     <= req_in;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            req_ready <= 1'b0;
        else
            req_ready <= cfg_done && free_ok && !(req_valid && req_ready);
    end

    // Issue; a retry drops the tenure and rotates priority past it
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            inflight_reg     <= 1'b0;
            inflight_idx_reg <= 2'h0;
            rr_ptr_reg       <= 2'h0;
            bus_request      <= 1'b0;
            issue_req        <= '0;
        end
        else
        begin
            bus_request <= 1'b0;
            if (inflight_reg && retry_seen_reg)
            begin
                inflight_reg <= 1'b0;
                rr_ptr_reg   <= inflight_idx_reg + 2'h1;
            end
            else if (inflight_reg && issue_done)
            begin
                inflight_reg <= 1'b0;
                rr_ptr_reg   <= inflight_idx_reg + 2'h1;
            end
            else if (!inflight_reg && pick_ok && !retry_seen_reg && !op_abort)
            begin
                inflight_reg     <= 1'b1;
                inflight_idx_reg <= pick_idx;
                bus_request      <= 1'b1;
                issue_req        <= buf_reg[pick_idx];
            end
        end
    end

    // Register image: ack enable, error flag, ratio, gating, timing, extension and pump fields; others zero
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            csr_read <= bcrc_pkg::CSR_RESET;
            cfg_out  <= bcrc_pkg::CFG_RESET;
        end
        else
        begin
            csr_read <= bcrc_pkg::CSR_RESET;
            csr_read[63-bcrc_pkg::POS_ACK_EN]  <= ack_error_check_enable_reg;
            csr_read[63-bcrc_pkg::POS_ACK_ERR] <= ack_missing_flag_reg;
            csr_read[63-bcrc_pkg::POS_RATIO -: 2] <= cfg.bus_core_ratio;
            csr_read[63-bcrc_pkg::POS_GATE]       <= cfg.bus_clock_gating_option;
            csr_read[63-bcrc_pkg::POS_RESPT -: 2] <= cfg.response_timing_enable;
            csr_read[63-bcrc_pkg::POS_DX]         <= cfg.data_extension_option;
            csr_read[63-bcrc_pkg::POS_PUMP]       <= cfg.pll_charge_pump_low;
            cfg_out <= cfg;
        end
    end

    // Assertions
    sequence s_retry_sampled;
        retry_now;
    endsequence

    sequence s_abort_pulse;
        ##1 retry_seen_reg ##1 op_abort;
    endsequence

    AST_ABORT_TIMING: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_retry_sampled |-> s_abort_pulse) else $error("Abort not two edges after retry");

    AST_MC_GATED: assert property (@(posedge sys_clk) disable iff (!arst_n)
        machine_check |-> $past(ack_error_check_enable_reg) && $past(missing_ack))
        else $error("Machine check without enable");

    AST_MC_RAISED: assert property (@(posedge sys_clk) disable iff (!arst_n)
        missing_ack && ack_error_check_enable_reg |=> machine_check)
        else $error("Enabled missing ack gave no machine check");

    AST_FLAG_SET: assert property (@(posedge sys_clk) disable iff (!arst_n)
        missing_ack |=> ack_missing_flag_reg) else $error("Flag not set on missing ack");

    AST_FLAG_CLEAR: assert property (@(posedge sys_clk) disable iff (!arst_n)
        csr_wr && !missing_ack |=> !ack_missing_flag_reg) else $error("Flag not cleared");

    AST_ABSENT_ACK_REPLY_SUBST: assert property (@(posedge sys_clk) disable iff (!arst_n)
        op_active && op_expects_ack && ack_reply == bcrc_pkg::ACK_ABSENT
        && !ack_error_check_enable_reg |=> op_ack_ok) else $error("Absent ack not substituted");

    AST_NO_QF_RETRY: assert property (@(posedge sys_clk) disable iff (!arst_n)
        aborted_reg |=> !addr_status_output && !addr_response_output)
        else $error("Queue-full retry after abort");

    AST_RESERVED_BUF: assert property (@(posedge sys_clk) disable iff (!arst_n)
        req_valid && req_ready && !(req_in.is_push && req_in.snoop)
        |=> !$changed(buf_vld_reg[bcrc_pkg::PUSH_BUF]) || $past(inflight_reg && issue_done))
        else $error("Reserved buffer taken by ordinary request");

    AST_REPRIO: assert property (@(posedge sys_clk) disable iff (!arst_n)
        inflight_reg && retry_seen_reg |=> rr_ptr_reg == $past(inflight_idx_reg) + 2'h1)
        else $error("No reprioritisation after retry");

    AST_ENABLE_RESET: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(arst_n) |-> !ack_error_check_enable_reg) else $error("Enable set at reset");

endmodule // bcrc_top

`default_nettype wire

// file: shared/bcrc_pkg.sv
// Shared constants and carrier types for the bus configuration and retry control block
package bcrc_pkg;

    // Bus acknowledge reply codes
    localparam logic [1:0] ACK_NONE      = 2'h0;
    localparam logic [1:0] ACK_ABSENT    = 2'h1;
    localparam logic [1:0] ACK_CONFIRMED = 2'h2;

    // Address status input codes
    localparam logic [1:0] ASTAT_NULL    = 2'h0;
    localparam logic [1:0] ASTAT_RETRY   = 2'h1;

    // Store buffer arrangement
    localparam int         NUM_BUF       = 4;
    localparam int         PUSH_BUF      = NUM_BUF - 1;
    localparam logic [1:0] PUSH_BUF_IDX  = 2'h3;

    // Abort delay after sampled retry, in bus cycles
    localparam int         ABORT_DELAY   = 1;

    // Configuration hold after reset release, in bus clocks
    localparam int         CFG_HOLD      = 3;
    localparam logic [1:0] CFG_HOLD_CNT  = 2'h3;

    // Control/status register layout, bit numbering 0 = most significant of 64
    localparam int         CSR_W         = 64;
    localparam int         POS_ACK_EN    = 21;
    localparam int         POS_ACK_ERR   = 22;
    localparam int         POS_RATIO     = 40;
    localparam int         POS_GATE      = 42;
    localparam int         POS_RESPT     = 44;
    localparam int         POS_DX        = 46;
    localparam int         POS_PUMP      = 47;
    localparam logic [63:0] CSR_RESET    = 64'h0;

    // Captured configuration pins
    typedef struct packed {
        logic       bus_clock_gating_option;
        logic [1:0] bus_core_ratio;
        logic       pll_charge_pump_low;
        logic [1:0] pll_vco_divider;
        logic [1:0] response_timing_enable;
        logic       data_extension_option;
        logic [4:0] bus_processor_id;
    } bcrc_cfg_t;

    localparam bcrc_cfg_t CFG_RESET = '0;

    // Raw configuration pin group
    typedef struct packed {
        logic       bus_clock_gating_pin;
        logic       scan_shift_gate_pin;
        logic       ratio_bit1_pin;
        logic       scan_clock_a_pin;
        logic       scan_clock_b_pin;
        logic       receiver_disable_pin;
        logic [1:0] response_timing_pin;
        logic       data_extension_pin;
        logic [2:0] processor_id_pin;
        logic       driver_disable_pin_a;
        logic       driver_disable_pin_b;
    } bcrc_pins_t;

    // Internal store request
    typedef struct packed {
        logic       is_push;
        logic       snoop;
        logic [1:0] tag;
    } bcrc_req_t;

endpackage : bcrc_pkg

// file: logic/bcrc_cfg_capture.sv
// Reset-time configuration pin capture
`timescale 1ns/100ps
`default_nettype none

module bcrc_cfg_capture
(
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  arst_n,
    // Pins
    input  wire bcrc_pkg::bcrc_pins_t  pins,
    input  wire logic                  scan_test_disable,
    // Captured configuration
    output var  bcrc_pkg::bcrc_cfg_t   cfg,
    output var  logic                  cfg_done
);

    bcrc_pkg::bcrc_pins_t pins_meta_reg;
    bcrc_pkg::bcrc_pins_t pins_sync_reg;
    logic                 tinh_meta_reg;
    logic                 tinh_sync_reg;
    logic [1:0]           hold_cnt_reg;
    bcrc_pkg::bcrc_cfg_t  cfg_next;

    // Pins are foreign to the clock, so two stages before use
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pins_meta_reg <= '0;
            pins_sync_reg <= '0;
            tinh_meta_reg <= 1'b0;
            tinh_sync_reg <= 1'b0;
        end
        else
        begin
            pins_meta_reg <= pins;
            pins_sync_reg <= pins_meta_reg;
            tinh_meta_reg <= scan_test_disable;
            tinh_sync_reg <= tinh_meta_reg;
        end
    end

    // Scan-class pins count only with scan test off
    always_comb
    begin
        cfg_next.bus_clock_gating_option  = pins_sync_reg.bus_clock_gating_pin;
        cfg_next.bus_core_ratio[1]        = pins_sync_reg.ratio_bit1_pin;
        cfg_next.bus_core_ratio[0]        = tinh_sync_reg & pins_sync_reg.scan_shift_gate_pin;
        cfg_next.pll_charge_pump_low      = tinh_sync_reg & pins_sync_reg.scan_clock_a_pin;
        cfg_next.pll_vco_divider[0]       = tinh_sync_reg & pins_sync_reg.scan_clock_b_pin;
        cfg_next.pll_vco_divider[1]       = tinh_sync_reg & pins_sync_reg.receiver_disable_pin;
        cfg_next.response_timing_enable   = pins_sync_reg.response_timing_pin;
        cfg_next.data_extension_option    = pins_sync_reg.data_extension_pin;
        cfg_next.bus_processor_id[2:0]    = pins_sync_reg.processor_id_pin;
        cfg_next.bus_processor_id[3]      = tinh_sync_reg & pins_sync_reg.driver_disable_pin_a;
        cfg_next.bus_processor_id[4]      = tinh_sync_reg & pins_sync_reg.driver_disable_pin_b;
    end

    // Track through the hold window; the sync delay of two fits inside the three-clock hold
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hold_cnt_reg <= 2'h0;
            cfg_done     <= 1'b0;
            cfg          <= bcrc_pkg::CFG_RESET;
        end
        else if (!cfg_done)
        begin
            cfg <= cfg_next;
            if (hold_cnt_reg == bcrc_pkg::CFG_HOLD_CNT)
                cfg_done <= 1'b1;
            else
                hold_cnt_reg <= hold_cnt_reg + 2'h1;
        end
    end

    AST_CFG_STABLE: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $past(cfg_done) |-> $stable(cfg)) else $error("Config changed after capture");

endmodule // bcrc_cfg_capture

`default_nettype wire

// file: bench/bcrc_far_model.sv
// Far-side model: board strapping of the configuration pins around hard reset
`timescale 1ns/100ps
`default_nettype none

module bcrc_far_model
(
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 arst_n,
    // Intended strap value
    input  wire bcrc_pkg::bcrc_pins_t strap,
    // Pins towards the device
    output var  bcrc_pkg::bcrc_pins_t cfg_pins
);
    logic [1:0] hold_reg;

    // Counts the hold window after reset release
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            hold_reg <= 2'h0;
        else if (hold_reg != bcrc_pkg::CFG_HOLD_CNT)
            hold_reg <= hold_reg + 2'h1;
    end

    // Strap driven through reset and three clocks; inverted after, so late capture shows
    assign cfg_pins = (hold_reg == bcrc_pkg::CFG_HOLD_CNT) ? ~strap : strap;

    // No non-retry memory is mapped write-back here, so no stimulus needs it
endmodule // bcrc_far_model

`default_nettype wire

// file: bench/tb_bcrc_top.sv
// Self-checking testbench for the bus configuration and retry control block
`timescale 1ns/100ps
`default_nettype none

module tb_bcrc_top;
    // Strap and expected capture: ratio and timing fields are 2'h3, so bit order is moot
    localparam bcrc_pkg::bcrc_pins_t STRAP   = 14'h3dd5;
    localparam bcrc_pkg::bcrc_cfg_t  CFG_EXP = 14'h3ed5;
    localparam logic [63:0]          CSR_EXP = 64'h0000_0000_00ed_0000;

    logic                 sys_clk, arst_n, scan_test_disable, csr_wr, csr_wr_ack_en;
    logic                 op_active, op_expects_ack, queue_full, req_valid, issue_done;
    logic [1:0]           ack_reply, addr_status_input;
    logic                 req_ready, bus_request, op_abort, op_ack_ok, machine_check;
    logic                 addr_status_output, addr_response_output;
    logic [63:0]          csr_read;
    bcrc_pkg::bcrc_pins_t cfg_pins;
    bcrc_pkg::bcrc_req_t  req_in, issue_req;
    bcrc_pkg::bcrc_cfg_t  cfg_out;
    int                   err_total, samples_checked, cycles, n_issue, n0;
    logic                 push_seen;

    bcrc_far_model bcrc_far_model_inst (.sys_clk(sys_clk), .arst_n(arst_n), .strap(STRAP),
        .cfg_pins(cfg_pins));

    bcrc_top bcrc_top_inst (.sys_clk(sys_clk), .arst_n(arst_n), .cfg_pins(cfg_pins),
        .scan_test_disable(scan_test_disable), .csr_wr(csr_wr), .csr_wr_ack_en(csr_wr_ack_en),
        .op_active(op_active), .op_expects_ack(op_expects_ack), .ack_reply(ack_reply),
        .addr_status_input(addr_status_input), .queue_full(queue_full), .req_in(req_in),
        .req_valid(req_valid), .issue_done(issue_done), .req_ready(req_ready),
        .bus_request(bus_request), .issue_req(issue_req), .op_abort(op_abort),
        .op_ack_ok(op_ack_ok), .machine_check(machine_check),
        .addr_status_output(addr_status_output), .addr_response_output(addr_response_output),
        .csr_read(csr_read), .cfg_out(cfg_out));

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic conclude();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Hang guard well above the expected run length
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            conclude();
        end
    end

    // Records each new tenure; bus_request stands one cycle
    always @(posedge sys_clk)
    begin
        if (bus_request === 1'b1)
        begin
            n_issue++;
            if (issue_req.is_push === 1'b1 && issue_req.snoop === 1'b1)
                push_seen = 1'b1;
        end
    end

    task automatic do_reset();
        @(negedge sys_clk) arst_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        arst_n = 1'b1;
        while (req_ready !== 1'b1) @(negedge sys_clk);
    endtask

    // One address tenure; answers stand one cycle, abort one cycle later still
    task automatic bus_op(input logic [1:0] reply, input logic [1:0] astat, input logic qf,
        input logic ok, input logic mc);
        @(negedge sys_clk);
        op_active = 1'b1;
        op_expects_ack = 1'b1;
        ack_reply = reply;
        addr_status_input = astat;
        queue_full = qf;
        @(posedge sys_clk);
        #1;
        chk_flag(op_ack_ok, ok);
        chk_flag(machine_check, mc);
        @(negedge sys_clk) op_active = 1'b0;
        ack_reply = bcrc_pkg::ACK_NONE;
        addr_status_input = bcrc_pkg::ASTAT_NULL;
        if (astat == bcrc_pkg::ASTAT_RETRY)
        begin
            @(posedge sys_clk);
            #1;
            chk_flag(op_abort, 1'b1);
            chk_flag(addr_status_output | addr_response_output, 1'b0);
        end
    endtask

    task automatic csr_write(input logic en);
        @(negedge sys_clk) csr_wr = 1'b1;
        csr_wr_ack_en = en;
        @(negedge sys_clk) csr_wr = 1'b0;
        repeat (3) @(negedge sys_clk);
    endtask

    // Held until a rising edge sees req_ready high
    task automatic send(input bcrc_pkg::bcrc_req_t r);
        @(negedge sys_clk) req_in = r;
        req_valid = 1'b1;
        while (req_ready !== 1'b1) @(negedge sys_clk);
        @(posedge sys_clk);
        @(negedge sys_clk) req_valid = 1'b0;
    endtask

    initial
    begin
        arst_n = 1'b0;
        scan_test_disable = 1'b1;
        {csr_wr, csr_wr_ack_en, op_active, op_expects_ack, queue_full} = 5'h00;
        {req_valid, issue_done, push_seen} = 3'h0;
        {ack_reply, addr_status_input} = 4'h0;
        req_in = '0;
        {err_total, samples_checked, cycles, n_issue} = {4{32'sh0}};
        do_reset();
        chk_val(64'(cfg_out), 64'(CFG_EXP));
        chk_val(csr_read, CSR_EXP);
        repeat (10) @(negedge sys_clk);
        chk_val(64'(cfg_out), 64'(CFG_EXP));
        // Enable clear: absent ack accepted, no machine check, flag still set
        bus_op(bcrc_pkg::ACK_ABSENT, bcrc_pkg::ASTAT_NULL, 1'b0, 1'b1, 1'b0);
        repeat (3) @(negedge sys_clk);
        chk_flag(csr_read[41], 1'b1);
        csr_write(1'b1);
        chk_flag(csr_read[41], 1'b0);
        chk_flag(csr_read[42], 1'b1);
        bus_op(bcrc_pkg::ACK_ABSENT, bcrc_pkg::ASTAT_NULL, 1'b0, 1'b0, 1'b1);
        bus_op(bcrc_pkg::ACK_CONFIRMED, bcrc_pkg::ASTAT_NULL, 1'b0, 1'b1, 1'b0);
        chk_flag(csr_read[41], 1'b1);
        // Fill the three ordinary slots with one in flight
        n0 = n_issue;
        send('{is_push: 1'b0, snoop: 1'b0, tag: 2'h0});
        while (n_issue == n0) @(negedge sys_clk);
        chk_val(64'(issue_req), 64'h0);
        send('{is_push: 1'b0, snoop: 1'b0, tag: 2'h1});
        send('{is_push: 1'b1, snoop: 1'b0, tag: 2'h2});
        @(negedge sys_clk) req_in = '{is_push: 1'b0, snoop: 1'b0, tag: 2'h3};
        req_valid = 1'b1;
        repeat (2) @(negedge sys_clk);
        repeat (6) @(negedge sys_clk) chk_flag(req_ready, 1'b0);
        req_valid = 1'b0;
        @(negedge sys_clk);
        send('{is_push: 1'b1, snoop: 1'b1, tag: 2'h3});
        // Retry with queue full, then a fresh tenure must follow
        n0 = n_issue;
        bus_op(bcrc_pkg::ACK_CONFIRMED, bcrc_pkg::ASTAT_RETRY, 1'b1, 1'b1, 1'b0);
        while (n_issue == n0) @(negedge sys_clk);
        // Priority rotates past the retried slot 0, so slot 1 goes next
        chk_val(64'(issue_req), 64'h1);
        @(negedge sys_clk);
        chk_flag(addr_status_output & addr_response_output, 1'b1);
        queue_full = 1'b0;
        repeat (6)
        begin
            @(negedge sys_clk) issue_done = 1'b1;
            @(negedge sys_clk) issue_done = 1'b0;
            repeat (4) @(negedge sys_clk);
        end
        chk_flag(push_seen, 1'b1);
        // Second reset clears enable and flag and recaptures the strap
        do_reset();
        chk_val(csr_read, CSR_EXP);
        chk_val(64'(cfg_out), 64'(CFG_EXP));
        // Scan test on: scan-class pins must not configure
        scan_test_disable = 1'b0;
        do_reset();
        chk_val(64'(cfg_out), 64'h30c5);
        chk_val(csr_read, 64'h0000_0000_00ac_0000);
        conclude();
    end
endmodule // tb_bcrc_top

`default_nettype wire
